// file: rtl/otx_pkg.sv
package otx_pkg;
  // opcode bytes
  localparam logic [7:0] OP_BAD_LO      = 8'h63;
  localparam logic [7:0] OP_BAD_HI      = 8'h67;
  localparam logic [7:0] OP_F1          = 8'hF1;
  localparam logic [7:0] OP_GRP4        = 8'hFE;
  localparam logic [7:0] OP_GRP5        = 8'hFF;
  localparam logic [7:0] OP_0F          = 8'h0F;
  localparam logic [7:0] OP_ESC_BASE    = 8'hD8;
  localparam logic [4:0] OP_ESC_TOP5    = 5'h1B;
  localparam logic [2:0] MODRM_REG_BAD  = 3'h7;
  localparam logic [7:0] OP_LOCK        = 8'hF0;
  localparam logic [7:0] OP_REP         = 8'hF3;
  localparam logic [7:0] OP_REPNE       = 8'hF2;
  localparam logic [7:0] OP_SEG_ES      = 8'h26;
  localparam logic [7:0] OP_SEG_CS      = 8'h2E;
  localparam logic [7:0] OP_SEG_SS      = 8'h36;
  localparam logic [7:0] OP_SEG_DS      = 8'h3E;
  localparam logic [7:0] OP_MOVSB       = 8'hA4;
  localparam logic [7:0] OP_MOVSW       = 8'hA5;
  // added and immediate forms
  localparam logic [7:0] OP_PUSHA       = 8'h60;
  localparam logic [7:0] OP_POP_ALL_REGISTERS        = 8'h61;
  localparam logic [7:0] OP_BOUND       = 8'h62;
  localparam logic [7:0] OP_PUSH_IMM16  = 8'h68;
  localparam logic [7:0] OP_SIGNED_MULTIPLY_IMM16  = 8'h69;
  localparam logic [7:0] OP_PUSH_IMM8   = 8'h6A;
  localparam logic [7:0] OP_SIGNED_MULTIPLY_IMM8   = 8'h6B;
  localparam logic [7:0] OP_INSB        = 8'h6C;
  localparam logic [7:0] OP_OUTSW       = 8'h6F;
  localparam logic [7:0] OP_SHIFT_IMM_B = 8'hC0;
  localparam logic [7:0] OP_SHIFT_IMM_W = 8'hC1;
  localparam logic [7:0] OP_ENTER       = 8'hC8;
  localparam logic [7:0] OP_LEAVE       = 8'hC9;
  // trap types and vector scaling
  localparam logic [7:0] TYPE_ILLEGAL   = 8'h06;
  localparam logic [7:0] TYPE_ESC       = 8'h07;
  localparam int         VEC_SHIFT      = 2;
  // arithmetic limits
  localparam logic [4:0]  SHIFT_MASK    = 5'h1F;
  localparam logic [15:0] SEG_END_OFS   = 16'hFFFF;
  localparam logic [16:0] SEG_WRAP_OFS  = 17'h10000;
  localparam logic [15:0] SP_UNDERFLOW  = 16'h0001;
  localparam logic [15:0] SP_WORD_STEP  = 16'h0002;
  localparam logic [3:0]  SEG_SHIFT     = 4'h4;
  localparam logic [19:0] ADDR_ONE      = 20'h00001;
  localparam logic [15:0] IP_ONE        = 16'h0001;
  localparam logic [16:0] Q16_POS_MAX   = 17'h07FFF;
  localparam logic [16:0] Q16_NEG_MIN   = 17'h18000;
  localparam logic [8:0]  Q8_POS_MAX    = 9'h07F;
  localparam logic [8:0]  Q8_NEG_MIN    = 9'h180;
  // coprocessor port window
  localparam logic [15:0] NPX_PORT_BASE = 16'h00F8;

  typedef enum logic [2:0] {
    OTX_IDLE   = 3'b000,
    OTX_LOCKED = 3'b001,
    OTX_DATA   = 3'b010,
    OTX_TRAP   = 3'b011,
    OTX_NPX    = 3'b100
  } otx_state_t;

  typedef enum logic [2:0] {
    OTX_CLS_NORMAL  = 3'b000,
    OTX_CLS_PREFIX  = 3'b001,
    OTX_CLS_ILLEGAL = 3'b010,
    OTX_CLS_ESC     = 3'b011,
    OTX_CLS_STRMOVE = 3'b100
  } otx_class_t;
endpackage : otx_pkg

// file: rtl/otx_ready_sync.sv
`timescale 1ns/1ps
module otx_ready_sync
  import otx_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // asynchronous ready
  input  wire logic ready_i,
  output logic      ready_o
);
  logic meta_reg;
  logic sync_reg;

  // two stages, first stage read only by the second
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= ready_i;
      sync_reg <= meta_reg;
    end
  end

  assign ready_o = sync_reg;
endmodule : otx_ready_sync

// file: rtl/otx_divchk.sv
`timescale 1ns/1ps
module otx_divchk
  import otx_pkg::*;
(
  // signed divide operands
  input  wire logic        word_i,
  input  wire logic [31:0] dividend_i,
  input  wire logic [15:0] divisor_i,
  // result
  output logic [15:0]      quot_o,
  output logic             err_o
);
  logic signed [31:0] q32;
  logic signed [31:0] dvd;
  logic signed [31:0] dvs;

  always_comb begin
    dvd = word_i ? dividend_i : {{16{dividend_i[15]}}, dividend_i[15:0]};
    dvs = word_i ? {{16{divisor_i[15]}}, divisor_i}
                 : {{24{divisor_i[7]}}, divisor_i[7:0]};
    q32 = (dvs == 32'sh0) ? 32'sh0 : dvd / dvs;
    quot_o = q32[15:0];
    // most negative quotient is legal
    if (dvs == 32'sh0) begin
      err_o = 1'b1;
    end else if (word_i) begin
      err_o = (q32 > $signed({{15{1'b0}}, Q16_POS_MAX}))
           || (q32 < $signed({{15{1'b1}}, Q16_NEG_MIN}));
    end else begin
      err_o = (q32 > $signed({{23{1'b0}}, Q8_POS_MAX}))
           || (q32 < $signed({{23{1'b1}}, Q8_NEG_MIN}));
    end
  end
endmodule : otx_divchk

// file: rtl/otx_core.sv
`timescale 1ns/1ps
// What this block does
// - opcodes 63H-67H and F1H trap type 6
// - FEH/FFH with reg field 111 trap 6
// - opcode 0FH traps type 6, no code pop
// - word write at FFFFH carries to 10000H
// - push with pointer 1 writes outside segment
// - shift counts masked to five bits
// - lock asserts only at data cycles
// - interrupted string move returns to first prefix
// - quotients 8000H and 80H are legal
// - escape trap enabled gives type 7
// - escape trap clear sends to coprocessor
// - three dedicated coprocessor handshake pins
// - one ready input, synchronised inside
// - fully static, state kept when clock stops
// - no queue status mode
// - immediate push, multiply, shift forms accepted
// - added push/pop all, strings, bound, enter, leave
// - coprocessor accesses wait for ready
module otx_core
  import otx_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // decoded byte stream
  input  wire logic        op_valid_i,
  input  wire logic [7:0]  op_byte_i,
  input  wire logic [7:0]  modrm_i,
  input  wire logic [15:0] op_ip_i,
  input  wire logic        irq_i,
  // configuration
  input  wire logic        escape_trap_enable_i,
  // shift request
  input  wire logic        shift_imm_i,
  input  wire logic [7:0]  count_register_i,
  input  wire logic [7:0]  shift_imm_val_i,
  // segment write request
  input  wire logic        wr_req_i,
  input  wire logic        wr_push_i,
  input  wire logic [15:0] wr_seg_i,
  input  wire logic [15:0] wr_ofs_i,
  input  wire logic [15:0] sp_i,
  // divide request
  input  wire logic        div_req_i,
  input  wire logic        div_word_i,
  input  wire logic [31:0] div_dividend_i,
  input  wire logic [15:0] div_divisor_i,
  // local bus
  input  wire logic        ready_i,
  input  wire logic        rd_strap_n_i,
  input  wire logic        npx_req_i,
  input  wire logic        npx_err_n_i,
  // exception and dispatch
  output logic             trap_o,
  output logic [7:0]       trap_type_o,
  output logic [9:0]       trap_vec_o,
  output logic [15:0]      trap_ret_ip_o,
  output logic             npx_dispatch_o,
  output logic             npx_sel_n_o,
  output logic             npx_busy_o,
  output logic             lock_n_o,
  output logic             ale_o,
  output logic             wr_n_o,
  // decode results
  output logic [4:0]       shift_cnt_o,
  output logic             ext_op_o,
  output logic             imm_form_o,
  output logic [19:0]      wr_addr_lo_o,
  output logic [19:0]      wr_addr_hi_o,
  output logic             wr_strobe_o,
  output logic [15:0]      div_quot_o,
  output logic             div_err_o
);

  function automatic otx_class_t classify(input logic [7:0] op, input logic [7:0] mrm);
    otx_class_t c;
    c = OTX_CLS_NORMAL;
    if ((op >= OP_BAD_LO && op <= OP_BAD_HI) || op == OP_F1) begin
      c = OTX_CLS_ILLEGAL;
    end else if ((op == OP_GRP4 || op == OP_GRP5) && mrm[5:3] == MODRM_REG_BAD) begin
      c = OTX_CLS_ILLEGAL;
    end else if (op == OP_0F) begin
      c = OTX_CLS_ILLEGAL;
    end else if (op[7:3] == OP_ESC_TOP5) begin
      c = OTX_CLS_ESC;
    end else if (op == OP_LOCK || op == OP_REP || op == OP_REPNE || op == OP_SEG_ES
                 || op == OP_SEG_CS || op == OP_SEG_SS || op == OP_SEG_DS) begin
      c = OTX_CLS_PREFIX;
    end else if (op == OP_MOVSB || op == OP_MOVSW) begin
      c = OTX_CLS_STRMOVE;
    end
    return c;
  endfunction : classify

  function automatic logic [19:0] lin_addr(input logic [15:0] seg, input logic [16:0] ofs);
    return 20'({seg, 4'h0}) + 20'(ofs);
  endfunction : lin_addr

  otx_class_t  cls;
  otx_state_t  state_reg;
  otx_state_t  state_next;
  logic        ready_sync;
  logic        lock_pend_reg;
  logic        in_prefix_reg;
  logic [15:0] first_ip_reg;
  logic        rep_seen_reg;
  logic [15:0] push_ofs;
  logic [16:0] wr_ofs_hi;
  logic [15:0] quot;
  logic        derr;

  assign cls = classify(op_byte_i, modrm_i);

  otx_ready_sync u_rdy (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ready_i (ready_i),
    .ready_o (ready_sync)
  );

  otx_divchk u_div (
    .word_i     (div_word_i),
    .dividend_i (div_dividend_i),
    .divisor_i  (div_divisor_i),
    .quot_o     (quot),
    .err_o      (derr)
  );

  // prefix tracking: remember where the first prefix started
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_prefix_reg <= 1'b0;
      first_ip_reg  <= 16'h0000;
      rep_seen_reg  <= 1'b0;
    end else if (op_valid_i) begin
      if (cls == OTX_CLS_PREFIX) begin
        if (!in_prefix_reg) begin
          first_ip_reg <= op_ip_i;
        end
        in_prefix_reg <= 1'b1;
        if (op_byte_i == OP_REP || op_byte_i == OP_REPNE) begin
          rep_seen_reg <= 1'b1;
        end
      end else if (!(cls == OTX_CLS_STRMOVE && rep_seen_reg && !irq_i)) begin
        in_prefix_reg <= 1'b0;
        rep_seen_reg  <= 1'b0;
      end
    end
  end

  // lock held back until the data phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_pend_reg <= 1'b0;
    end else if (op_valid_i) begin
      if (op_byte_i == OP_LOCK) begin
        lock_pend_reg <= 1'b1;
      end else if (cls != OTX_CLS_PREFIX) begin
        lock_pend_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      OTX_IDLE: begin
        if (op_valid_i) begin
          if (cls == OTX_CLS_ILLEGAL) begin
            state_next = OTX_TRAP;
          end else if (cls == OTX_CLS_ESC) begin
            state_next = escape_trap_enable_i ? OTX_TRAP : OTX_NPX;
          end else if (cls != OTX_CLS_PREFIX && lock_pend_reg) begin
            state_next = OTX_LOCKED;
          end
        end
      end
      OTX_LOCKED: state_next = OTX_DATA;
      OTX_DATA:   state_next = OTX_IDLE;
      OTX_TRAP:   state_next = OTX_IDLE;
      OTX_NPX: begin
        if (ready_sync) begin
          state_next = OTX_IDLE;
        end
      end
      default:    state_next = OTX_IDLE;
    endcase
  end

  // state kept in plain flops, no dynamic nodes; clock may stop anywhere
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= OTX_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // trap outputs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trap_o        <= 1'b0;
      trap_type_o   <= 8'h00;
      trap_vec_o    <= 10'h000;
      trap_ret_ip_o <= 16'h0000;
    end else begin
      trap_o <= 1'b0;
      if (state_reg == OTX_IDLE && op_valid_i) begin
        if (cls == OTX_CLS_ILLEGAL) begin
          trap_o      <= 1'b1;
          trap_type_o <= TYPE_ILLEGAL;
          trap_vec_o  <= 10'({TYPE_ILLEGAL, 2'b00});
          trap_ret_ip_o <= op_ip_i;
        end else if (cls == OTX_CLS_ESC && escape_trap_enable_i) begin
          trap_o      <= 1'b1;
          trap_type_o <= TYPE_ESC;
          trap_vec_o  <= 10'({TYPE_ESC, 2'b00});
          trap_ret_ip_o <= op_ip_i;
        end else if (cls == OTX_CLS_STRMOVE && irq_i) begin
          // interrupt mid string move resumes at first prefix
          trap_ret_ip_o <= in_prefix_reg ? first_ip_reg : op_ip_i;
        end
      end
    end
  end

  // coprocessor: dedicated select, request and error pins, never shared
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      npx_dispatch_o <= 1'b0;
      npx_sel_n_o    <= 1'b1;
      npx_busy_o     <= 1'b0;
    end else begin
      npx_dispatch_o <= state_reg == OTX_IDLE && op_valid_i && cls == OTX_CLS_ESC
                        && !escape_trap_enable_i;
      npx_sel_n_o    <= !(state_next == OTX_NPX);
      npx_busy_o     <= (state_next == OTX_NPX) && (npx_req_i || npx_err_n_i);
    end
  end

  // lock, ale and write strobe keep their meaning regardless of read strap
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_n_o <= 1'b1;
      ale_o    <= 1'b0;
      wr_n_o   <= 1'b1;
    end else begin
      lock_n_o <= !(state_next == OTX_DATA);
      ale_o    <= wr_req_i || state_next == OTX_NPX;
      wr_n_o   <= !wr_req_i;
    end
  end

  // shift count and instruction-set decode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_cnt_o <= 5'h00;
      ext_op_o    <= 1'b0;
      imm_form_o  <= 1'b0;
    end else begin
      shift_cnt_o <= (shift_imm_i ? shift_imm_val_i[4:0] : count_register_i[4:0])
                     & SHIFT_MASK;
      ext_op_o    <= op_valid_i && (op_byte_i == OP_PUSHA || op_byte_i == OP_POP_ALL_REGISTERS
                     || op_byte_i == OP_BOUND || (op_byte_i >= OP_INSB
                     && op_byte_i <= OP_OUTSW) || op_byte_i == OP_ENTER
                     || op_byte_i == OP_LEAVE);
      imm_form_o  <= op_valid_i && ((op_byte_i >= OP_PUSH_IMM16
                     && op_byte_i <= OP_SIGNED_MULTIPLY_IMM8) || op_byte_i == OP_SHIFT_IMM_B
                     || op_byte_i == OP_SHIFT_IMM_W);
    end
  end

  // word write: high byte never wraps to offset zero
  assign push_ofs  = sp_i - SP_WORD_STEP;
  assign wr_ofs_hi = wr_push_i ? (17'(push_ofs) + 17'(IP_ONE))
                               : (17'(wr_ofs_i) + 17'(IP_ONE));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_addr_lo_o <= 20'h00000;
      wr_addr_hi_o <= 20'h00000;
      wr_strobe_o  <= 1'b0;
    end else begin
      wr_strobe_o <= wr_req_i;
      if (wr_req_i) begin
        if (wr_push_i && sp_i == SP_UNDERFLOW) begin
          // sp-2 = FFFFH, high byte lands one past segment end
          wr_addr_lo_o <= lin_addr(wr_seg_i, 17'(SEG_END_OFS));
          wr_addr_hi_o <= lin_addr(wr_seg_i, SEG_WRAP_OFS);
        end else begin
          wr_addr_lo_o <= lin_addr(wr_seg_i, wr_push_i ? 17'(push_ofs) : 17'(wr_ofs_i));
          wr_addr_hi_o <= lin_addr(wr_seg_i, wr_ofs_hi);
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_quot_o <= 16'h0000;
      div_err_o  <= 1'b0;
    end else if (div_req_i) begin
      div_quot_o <= quot;
      div_err_o  <= derr;
    end
  end
endmodule : otx_core

// file: verif/otx_core_assertions.sv
`timescale 1ns/1ps
module otx_core_assertions
  import otx_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // watched inputs
  input wire logic        op_valid_i,
  input wire logic [7:0]  op_byte_i,
  input wire logic [7:0]  modrm_i,
  input wire logic        escape_trap_enable_i,
  input wire logic        shift_imm_i,
  input wire logic [7:0]  count_register_i,
  input wire logic [7:0]  shift_imm_val_i,
  input wire logic        wr_req_i,
  input wire logic        wr_push_i,
  input wire logic [15:0] wr_seg_i,
  input wire logic [15:0] wr_ofs_i,
  input wire logic [15:0] sp_i,
  input wire logic        div_req_i,
  input wire logic [15:0] div_divisor_i,
  input wire logic        ready_i,
  // watched outputs
  input wire logic        trap_o,
  input wire logic [7:0]  trap_type_o,
  input wire logic [9:0]  trap_vec_o,
  input wire logic        npx_dispatch_o,
  input wire logic        npx_sel_n_o,
  input wire logic        lock_n_o,
  input wire logic [4:0]  shift_cnt_o,
  input wire logic [19:0] wr_addr_lo_o,
  input wire logic [19:0] wr_addr_hi_o,
  input wire logic        wr_strobe_o,
  input wire logic        div_err_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic        op_ill;
  logic        op_esc;
  logic [4:0]  cnt_src;
  logic [15:0] ofs_eff;
  logic [19:0] lo_exp;
  assign op_ill  = op_valid_i && ((op_byte_i >= OP_BAD_LO && op_byte_i <= OP_BAD_HI) ||
                   op_byte_i == OP_F1 || op_byte_i == OP_0F ||
                   ((op_byte_i == OP_GRP4 || op_byte_i == OP_GRP5) &&
                    modrm_i[5:3] == MODRM_REG_BAD));
  assign op_esc  = op_valid_i && op_byte_i[7:3] == OP_ESC_TOP5;
  assign cnt_src = shift_imm_i ? shift_imm_val_i[4:0] : count_register_i[4:0];
  assign ofs_eff = wr_push_i ? sp_i - SP_WORD_STEP : wr_ofs_i;
  assign lo_exp  = {wr_seg_i, 4'h0} + {4'h0, ofs_eff};

  property p_ill; op_ill |=> trap_o && trap_type_o == TYPE_ILLEGAL; endproperty
  a_ill: assert property (p_ill)
    else $error("illegal opcode not trapped");
  property p_vec; trap_o |-> trap_vec_o == {trap_type_o, 2'b00}; endproperty
  a_vec: assert property (p_vec)
    else $error("trap vector not type times four");
  property p_esc_trap; op_esc && escape_trap_enable_i |=> trap_o && trap_type_o == TYPE_ESC;
  endproperty
  a_esc_trap: assert property (p_esc_trap)
    else $error("escape opcode not trapped");
  property p_esc_disp; op_esc && !escape_trap_enable_i |=> npx_dispatch_o && !npx_sel_n_o && !trap_o;
  endproperty
  a_esc_disp: assert property (p_esc_disp)
    else $error("escape opcode not dispatched");
  property p_shift; rstn_i |=> shift_cnt_o == $past(cnt_src); endproperty
  a_shift: assert property (p_shift)
    else $error("shift count not masked");
  property p_lock; op_valid_i && op_byte_i == OP_LOCK |=> lock_n_o ##[1:3] !lock_n_o; endproperty
  a_lock: assert property (p_lock)
    else $error("lock timing wrong");
  property p_wr;
    wr_req_i |=> wr_strobe_o && wr_addr_lo_o == $past(lo_exp) &&
                 wr_addr_hi_o == $past(lo_exp) + ADDR_ONE;
  endproperty
  a_wr: assert property (p_wr)
    else $error("word write addresses wrong");
  property p_div0; div_req_i && div_divisor_i == 16'h0000 |=> div_err_o; endproperty
  a_div0: assert property (p_div0)
    else $error("divide by zero not flagged");
  // ready passes two flops, so three low samples keep the select held
  property p_npx_hold;
    !npx_sel_n_o && !ready_i && !$past(ready_i) && !$past(ready_i, 2) |=> !npx_sel_n_o;
  endproperty
  a_npx_hold: assert property (p_npx_hold)
    else $error("coprocessor cycle ended without ready");
  c_ill: cover property (op_ill);
  c_disp: cover property (op_esc && !escape_trap_enable_i);
  c_push: cover property (wr_req_i && wr_push_i && sp_i == SP_UNDERFLOW);
endmodule : otx_core_assertions

bind otx_core otx_core_assertions otx_core_assertions_inst (.*);

// file: verif/otx_npx_model.sv
`timescale 1ns/1ps
module otx_npx_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // core side
  input  wire logic npx_sel_n_i,
  input  wire logic slow_i,
  output logic      ready_o,
  output logic      npx_req_o,
  output logic      npx_err_n_o
);
  int unsigned wait_cnt;
  // ready moves off the edge on purpose: the core has to synchronise it
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_cnt = 0;
      ready_o <= 1'b0;
    end else if (npx_sel_n_i) begin
      wait_cnt = 0;
      ready_o <= #1.3 1'b0;
    end else begin
      wait_cnt = wait_cnt + 1;
      if (wait_cnt > (slow_i ? 6 : 1)) ready_o <= #1.3 1'b1;
    end
  end
  assign npx_req_o   = !npx_sel_n_i && !ready_o;
  assign npx_err_n_o = 1'b1;
endmodule : otx_npx_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import otx_pkg::*;
;
  logic        clk_i = 1'b0, rstn_i = 1'b0, clk_run = 1'b1, slow = 1'b0;
  logic        op_valid_i, irq_i, escape_trap_enable_i, shift_imm_i, wr_req_i, wr_push_i;
  logic        div_req_i, div_word_i, ready_i, rd_strap_n_i, npx_req_i, npx_err_n_i;
  logic [7:0]  op_byte_i, modrm_i, count_register_i, shift_imm_val_i, trap_type_o;
  logic [15:0] op_ip_i, wr_seg_i, wr_ofs_i, sp_i, div_divisor_i, trap_ret_ip_o, div_quot_o;
  logic [31:0] div_dividend_i;
  logic        trap_o, npx_dispatch_o, npx_sel_n_o, npx_busy_o, lock_n_o, ale_o, wr_n_o;
  logic        ext_op_o, imm_form_o, wr_strobe_o, div_err_o;
  logic [9:0]  trap_vec_o;
  logic [4:0]  shift_cnt_o;
  logic [19:0] wr_addr_lo_o, wr_addr_hi_o;
  int          n_fail = 0, n_compared = 0, cnt;
  // row: opcode, modrm, flags {enable, trap, type 7, dispatch, added, immediate, 2'b00}
  logic [23:0] rows [27] = '{24'h630040, 24'h640040, 24'h650040, 24'h660040, 24'h670040,
    24'hF10040, 24'h0F0040, 24'hFE3840, 24'hFFF840, 24'hFE0000, 24'hD800E0, 24'hDF00E0,
    24'hD80010, 24'hDD0010, 24'h600008, 24'h610008, 24'h620008, 24'h6C0008, 24'h6F0008,
    24'hC80008, 24'hC90008, 24'h680004, 24'h690004, 24'h6A0004, 24'h6B0004, 24'hC00004,
    24'hC10004};

  always #2 if (clk_run) clk_i = ~clk_i;

  otx_core otx_core_inst (.*);
  otx_npx_model otx_npx_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .npx_sel_n_i(npx_sel_n_o),
    .slow_i(slow), .ready_o(ready_i), .npx_req_o(npx_req_i), .npx_err_n_o(npx_err_n_i));

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic dec(input logic [7:0] op, input logic [7:0] m, input logic [15:0] ip);
    op_byte_i  = op;
    modrm_i    = m;
    op_ip_i    = ip;
    op_valid_i = 1'b1;
    tick(1);
  endtask : dec

  task automatic wr(input logic [15:0] seg, ofs, sp, input logic push, input logic [19:0] lo, hi);
    wr_seg_i  = seg;
    wr_ofs_i  = ofs;
    sp_i      = sp;
    wr_push_i = push;
    wr_req_i  = 1'b1;
    tick(1);
    wr_req_i = 1'b0;
    chk("wr_strobe_o", wr_strobe_o, 1'b1);
    chk("wr_n_o", wr_n_o, 1'b0);
    chk("ale_o", ale_o, 1'b1);
    chk("wr_addr_lo_o", wr_addr_lo_o, lo);
    chk("wr_addr_hi_o", wr_addr_hi_o, hi);
    tick(1);
  endtask : wr

  task automatic dv(input logic w, input logic [31:0] dd, input logic [7:0] q, input logic e);
    div_word_i     = w;
    div_dividend_i = dd;
    div_divisor_i  = 16'h0001;
    div_req_i      = 1'b1;
    tick(1);
    div_req_i = 1'b0;
    chk("div_err_o", div_err_o, e);
    if (!e) chk("div_quot_o", div_quot_o[7:0], q);
    tick(1);
  endtask : dv

  task automatic print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  initial begin
    {op_valid_i, irq_i, escape_trap_enable_i, shift_imm_i, wr_req_i, wr_push_i} = '0;
    {div_req_i, div_word_i, rd_strap_n_i} = '0;
    {op_byte_i, modrm_i, count_register_i, shift_imm_val_i} = '0;
    {op_ip_i, wr_seg_i, wr_ofs_i, sp_i, div_divisor_i, div_dividend_i} = '0;
    // read strap held low through reset must not change the strobes
    repeat (12) @(posedge clk_i);
    #1;
    chk("ale_o", ale_o, 1'b0);
    chk("wr_n_o", wr_n_o, 1'b1);
    chk("lock_n_o", lock_n_o, 1'b1);
    rstn_i = 1'b1;
    tick(1);
    foreach (rows[i]) begin
      slow = i[0];
      escape_trap_enable_i = rows[i][7];
      dec(rows[i][23:16], rows[i][15:8], 16'h0200);
      op_valid_i = 1'b0;
      chk("trap_o", trap_o, rows[i][6]);
      if (rows[i][6]) chk("trap_type_o", trap_type_o, rows[i][5] ? TYPE_ESC : TYPE_ILLEGAL);
      if (rows[i][6]) chk("trap_vec_o", trap_vec_o, rows[i][5] ? 10'h01C : 10'h018);
      chk("npx_dispatch_o", npx_dispatch_o, rows[i][4]);
      chk("npx_busy_o", npx_busy_o, rows[i][4]);
      chk("ext_op_o", ext_op_o, rows[i][3]);
      chk("imm_form_o", imm_form_o, rows[i][2]);
      cnt = 0;
      while (npx_sel_n_o !== 1'b1 && cnt < 50) begin
        tick(1);
        cnt++;
      end
      if (rows[i][4]) chk("npx wait", cnt > (slow ? 6 : 1), 1'b1);
      tick(4);
    end
    count_register_i = 8'h25;
    tick(1);
    chk("shift_cnt_o", shift_cnt_o, 5'h05);
    count_register_i = 8'h20;
    tick(1);
    chk("shift_cnt_o", shift_cnt_o, 5'h00);
    shift_imm_i     = 1'b1;
    shift_imm_val_i = 8'hFF;
    tick(1);
    chk("shift_cnt_o", shift_cnt_o, 5'h1F);
    wr(16'h1234, 16'hFFFF, 16'h0000, 1'b0, 20'h2233F, 20'h22340);
    wr(16'h1000, 16'h0000, 16'h0001, 1'b1, 20'h1FFFF, 20'h20000);
    dv(1'b1, 32'h00008000, 8'h00, 1'b1);
    dv(1'b0, 32'h00000080, 8'h00, 1'b1);
    dv(1'b0, 32'h0000FF80, 8'h80, 1'b0);
    dv(1'b1, 32'hFFFF8000, 8'h00, 1'b0);
    chk("div_quot_o", div_quot_o, 16'h8000);
    // stop the clock for a long stretch, state must survive
    clk_run = 1'b0;
    #200;
    clk_run = 1'b1;
    tick(2);
    chk("div_quot_o", div_quot_o, 16'h8000);
    // zero divisor must always flag an error
    div_divisor_i = 16'h0000;
    div_req_i     = 1'b1;
    tick(1);
    div_req_i = 1'b0;
    chk("div_err_o", div_err_o, 1'b1);
    dec(OP_LOCK, 8'h00, 16'h0300);
    chk("lock_n_o", lock_n_o, 1'b1);
    dec(8'h89, 8'h00, 16'h0301);
    op_valid_i = 1'b0;
    cnt = 0;
    while (lock_n_o !== 1'b0 && cnt < 4) begin
      tick(1);
      cnt++;
    end
    chk("lock_n_o", lock_n_o, 1'b0);
    tick(4);
    dec(OP_REP, 8'h00, 16'h0100);
    dec(OP_SEG_ES, 8'h00, 16'h0101);
    irq_i = 1'b1;
    dec(OP_MOVSB, 8'h00, 16'h0102);
    op_valid_i = 1'b0;
    irq_i = 1'b0;
    chk("trap_ret_ip_o", trap_ret_ip_o, 16'h0100);
    tick(4);
    dec(OP_BAD_LO, 8'h00, 16'h0400);
    op_valid_i = 1'b0;
    chk("trap_o", trap_o, 1'b1);
    print_verdict();
  end
endmodule : tb_top
